// [dv/cdc_analog_model.sv]
// analog comparator front end model
`timescale 1ns/100ps
`default_nettype none
module cdc_analog_model
(
    input wire logic [7:0] vpos,
    input wire logic [7:0] vneg_pin,
    input wire logic [6:0] ladder_level_code,
    input wire logic       neg_source_select,
    input wire logic       block_power_down,
    output wire logic      comparator_raw_in
);
// levels in 1/128 of the reference
wire [7:0] vneg = neg_source_select ? {1'b0, ladder_level_code} : vneg_pin;
assign comparator_raw_in = block_power_down | (vpos > vneg);
endmodule // cdc_analog_model
`default_nettype wire

// [dv/cdc_comparator_ctl_props.sv]
// port checker for the comparator control block
`timescale 1ns/100ps
`default_nettype none
module cdc_comparator_ctl_props
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic       block_power_down,
    input wire logic       neg_source_select,
    input wire logic [2:0] neg_ext_input_select,
    input wire logic [2:0] pos_ext_input_select,
    input wire logic [3:0] neg_pin_connect,
    input wire logic [2:0] pos_pin_connect,
    input wire logic       conditioned_compare_out,
    input wire logic       compare_pin_out,
    input wire logic       compare_pin_out_enable_n,
    input wire logic       compare_irq,
    input wire logic       block_irq
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
wire wr = psel & penable & pwrite;
sequence s_cond_seen;
    $past(conditioned_compare_out) || $past(conditioned_compare_out, 2);
endsequence
property p_pin; !compare_pin_out_enable_n |-> compare_pin_out == conditioned_compare_out; endproperty
a_pin: assert property (p_pin) else $error("pin out differs");
property p_oe; $changed(compare_pin_out_enable_n) |-> $past(wr); endproperty
a_oe: assert property (p_oe) else $error("pin enable moved");
property p_pd; $changed(block_power_down) |-> $past(wr); endproperty
a_pd: assert property (p_pd) else $error("power down moved");
property p_noff; neg_source_select || neg_ext_input_select[2] |-> neg_pin_connect == 4'h0; endproperty
a_noff: assert property (p_noff) else $error("neg pin on");
property p_non; !neg_source_select && !neg_ext_input_select[2] |-> neg_pin_connect ==
    (neg_ext_input_select == 3'h2 ? 4'h0 : 4'h1 << neg_ext_input_select[1:0]); endproperty
a_non: assert property (p_non) else $error("neg pin wrong");
property p_pos; pos_pin_connect == (pos_ext_input_select[2] || pos_ext_input_select == 3'h3 ?
    3'h0 : 3'h1 << pos_ext_input_select[1:0]); endproperty
a_pos: assert property (p_pos) else $error("pos pin wrong");
property p_irq_up; $rose(compare_irq) |-> $past(wr) or s_cond_seen; endproperty
a_irq_up: assert property (p_irq_up) else $error("irq without cause");
property p_irq_dn; $fell(compare_irq) |-> $past(wr); endproperty
a_irq_dn: assert property (p_irq_dn) else $error("irq dropped alone");
property p_birq_dn; $fell(block_irq) |-> $past(wr); endproperty
a_birq_dn: assert property (p_birq_dn) else $error("block irq dropped alone");
endmodule // cdc_comparator_ctl_props
bind cdc_comparator_ctl cdc_comparator_ctl_props u_props(.pclk, .presetn, .psel, .penable,
    .pwrite, .block_power_down, .neg_source_select, .neg_ext_input_select,
    .pos_ext_input_select, .neg_pin_connect, .pos_pin_connect, .conditioned_compare_out,
    .compare_pin_out, .compare_pin_out_enable_n, .compare_irq, .block_irq);
`default_nettype wire

// [dv/comparator_dac_control_bench.sv]
// self-checking bench for the comparator control block
`timescale 1ns/100ps
`default_nettype none
`include "cdc_defs.vh"
module comparator_dac_control_bench;
logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
logic [13:0] paddr = 0;
logic [31:0] pwdata = 0, prdata, rd;
logic [7:0]  vpos = 8'h00, vneg_pin = 8'h00;
logic        pready, pslverr, comparator_raw_in, block_power_down, ladder_ref_select;
logic        neg_source_select, conditioned_compare_out, compare_pin_out, block_irq;
logic        compare_pin_out_enable_n, compare_irq;
logic [1:0]  bandgap_level_select;
logic [6:0]  ladder_level_code;
logic [2:0]  neg_ext_input_select, pos_ext_input_select, pos_pin_connect;
logic [3:0]  neg_pin_connect;
int          miscompares = 0, comparisons = 0, i, m, c, nd;
logic [11:0] ix [6] = '{12'h00D, 12'h00E, 12'h019, 12'h18D, 12'h18E, 12'h18F};
logic [7:0]  rv [6] = '{8'h00, 8'h00, 8'h1F, 8'hC0, 8'hFF, 8'h00};
initial forever #12.5 pclk = ~pclk;
cdc_comparator_ctl dut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .comparator_raw_in, .block_power_down, .ladder_ref_select,
    .bandgap_level_select, .ladder_level_code, .neg_source_select, .neg_ext_input_select,
    .pos_ext_input_select, .neg_pin_connect, .pos_pin_connect, .conditioned_compare_out,
    .compare_pin_out, .compare_pin_out_enable_n, .compare_irq, .block_irq);
cdc_analog_model u_ana(.vpos, .vneg_pin, .ladder_level_code, .neg_source_select,
    .block_power_down, .comparator_raw_in);
function logic [3:0] f_neg(input logic [2:0] s);
    f_neg = s[2] || s == 3'h2 ? 4'h0 : 4'h1 << s[1:0];
endfunction
function logic [2:0] f_pos(input logic [2:0] s);
    f_pos = s[2] || s == 3'h3 ? 3'h0 : 3'h1 << s[1:0];
endfunction
task tally_and_finish(input bit hang);
    miscompares += hang;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
endtask
task chk(input bit ok);
    comparisons++;
    if (!ok)
        $display("[ERR] %0t mismatch %0d", $time, ++miscompares);
endtask
task apb(input bit w, input [11:0] idx, input [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    for (n = 0; pready !== 1'b1; n++)
    begin
        if (n > 20)
            tally_and_finish(1);
        @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    // let the write settle before outputs are compared
    @(negedge pclk);
endtask
task wait_cond(input bit v);
    for (c = 0; conditioned_compare_out !== v && c < 40; c++)
        @(negedge pclk);
endtask
initial
begin
    void'($urandom(32'h9318));
    repeat (16) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 6; i++)
    begin
        apb(0, ix[i], 8'h00);
        chk(rd === {24'h0, rv[i]} && err === 1'b0);
    end
    apb(0, 12'h100, 8'h00);
    chk(rd === 32'h0 && err === 1'b1);
    for (i = 0; i < 8; i++)
    begin
        apb(1, `CDC_IDX_IN_SEL, {1'b0, i[2:0], 1'b1, i[2:0]});
        chk(neg_pin_connect === f_neg(i[2:0]) && pos_pin_connect === f_pos(i[2:0]));
    end
    apb(1, `CDC_IDX_IN_SEL, 8'h80);
    apb(1, `CDC_IDX_CMP_CTL, 8'h00);
    chk(block_power_down === 1'b0 && neg_source_select === 1'b1);
    for (i = 0; i < 8; i++)
    begin
        m = $urandom_range(107, 20);
        apb(1, `CDC_IDX_LADDER, {i[0], m[6:0]});
        chk(ladder_ref_select === i[0] && ladder_level_code === m[6:0]);
        vpos <= i[1] ? m + 5 : m - 5;
        repeat (8) @(posedge pclk);
        apb(0, `CDC_IDX_CMP_CTL, 8'h00);
        chk(rd[6] === i[1]);
    end
    apb(1, `CDC_IDX_REF_CHAN, 8'h7F);
    apb(0, `CDC_IDX_REF_CHAN, 8'h00);
    chk(bandgap_level_select === 2'b01 && rd === 32'h5F);
    apb(1, `CDC_IDX_LADDER, 8'h40);
    for (i = 0; i < 4; i++)
    begin
        nd = i == 0 ? 0 : 2 << i;
        apb(1, `CDC_IDX_CMP_CTL, i[7:0]);
        vpos <= 8'h00;
        repeat (30) @(posedge pclk);
        vpos <= 8'h60;
        if (i > 0)
        begin
            repeat (nd - 1) @(posedge pclk);
            vpos <= 8'h00;
        end
        wait_cond(1);
        if (i > 0)
            chk(c === 40);
        vpos <= 8'h60;
        wait_cond(1);
        if (i > 0)
            chk(c >= nd + 3 && c <= nd + 6);
    end
    apb(1, `CDC_IDX_CMP_CTL, 8'h10);
    repeat (4) @(posedge pclk);
    chk(conditioned_compare_out === 1'b0);
    apb(1, `CDC_IDX_CMP_CTL, 8'h20);
    repeat (3) @(posedge pclk);
    chk(compare_pin_out_enable_n === 1'b0 && compare_pin_out === 1'b1);
    apb(1, `CDC_IDX_IRQ_EN, 8'h10);
    for (m = 0; m < 4; m++)
    begin
        apb(1, `CDC_IDX_CMP_CTL, {4'h0, m[1:0], 2'b00});
        vpos <= 8'h00;
        repeat (8) @(posedge pclk);
        apb(1, `CDC_IDX_IRQ_FLAG, 8'h00);
        apb(0, `CDC_IDX_IRQ_FLAG, 8'h00);
        chk(rd[4] === 1'b0 && compare_irq === 1'b0);
        vpos <= 8'h60;
        repeat (8) @(posedge pclk);
        apb(0, `CDC_IDX_IRQ_FLAG, 8'h00);
        chk(rd[4] === (m != 1) && compare_irq === (m != 1));
        if (m == 0)
        begin
            apb(0, `CDC_IDX_IRQ_STAT, 8'h00);
            chk(rd[0] === 1'b1 && block_irq === 1'b0);
            apb(1, `CDC_IDX_IRQ_MASK, 8'h01);
            apb(0, `CDC_IDX_IRQ_STAT, 8'h00);
            chk(block_irq === 1'b1);
            apb(1, `CDC_IDX_IRQ_CLR, 8'h01);
            apb(0, `CDC_IDX_IRQ_STAT, 8'h00);
            chk(rd[0] === 1'b0 && block_irq === 1'b0);
        end
        apb(1, `CDC_IDX_IRQ_FLAG, 8'h00);
        vpos <= 8'h00;
        repeat (8) @(posedge pclk);
        apb(0, `CDC_IDX_IRQ_FLAG, 8'h00);
        chk(rd[4] === (m != 0));
    end
    apb(1, `CDC_IDX_IRQ_EN, 8'h00);
    apb(0, `CDC_IDX_IRQ_FLAG, 8'h00);
    chk(rd[4] === 1'b1 && compare_irq === 1'b0);
    apb(1, `CDC_IDX_IRQ_FLAG, 8'h00);
    apb(1, `CDC_IDX_CMP_CTL, 8'h80);
    repeat (8) @(posedge pclk);
    apb(0, `CDC_IDX_IRQ_FLAG, 8'h00);
    chk(rd[4] === 1'b1);
    apb(0, `CDC_IDX_CMP_CTL, 8'h00);
    chk(rd[7:6] === 2'b11);
    tally_and_finish(0);
end
endmodule // comparator_dac_control_bench
`default_nettype wire

// [rtl/cdc_comparator_ctl.v]
// comparator and reference ladder control block with apb register slave
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cdc_defs.vh"

// Operation
// - seven-bit ladder code, output code over 128
// - bandgap level field sets 1.20V or 2.48V
// - power-down bit stops comparator and ladder
// - raw status low only when positive at or below negative
// - negative source: external pin or ladder
// - negative pin select, 1xx unconnected
// - positive pin select, 1xx unconnected
// - de-bounce none, 4, 8, 16 cycles
// - invert bit forms conditioned output
// - pin enable drives conditioned output out
// - trigger sets flag, writing zero clears
// - enable bit gates flag onto interrupt
module cdc_comparator_ctl
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [13:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        comparator_raw_in,
    output wire        block_power_down,
    output wire        ladder_ref_select,
    output wire [1:0]  bandgap_level_select,
    output wire [6:0]  ladder_level_code,
    output wire        neg_source_select,
    output wire [2:0]  neg_ext_input_select,
    output wire [2:0]  pos_ext_input_select,
    output wire [3:0]  neg_pin_connect,
    output wire [2:0]  pos_pin_connect,
    output wire        conditioned_compare_out,
    output wire        compare_pin_out,
    output wire        compare_pin_out_enable_n,
    output wire        compare_irq,
    output wire        block_irq
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg  [7:0]  irq_en_r;
    reg         flag_r;
    reg  [7:0]  ref_chan_r;
    reg  [7:0]  cmp_ctl_r;
    reg  [7:0]  in_sel_r;
    reg  [7:0]  ladder_r;
    reg         stat_r;
    reg         mask_r;
    reg  [31:0] prdata_r;
    reg         sync1_r;
    reg         sync2_r;
    reg         deb_r;
    reg  [4:0]  deb_cnt_r;
    reg         cond_prev_r;
    reg         cond_r;
    reg         pin_r;

    wire [11:0] idx = paddr[13:2];
    wire        wr_en = psel & penable & pwrite;
    wire        rd_en = psel & penable & ~pwrite;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `CDC_IDX_IRQ_EN) || (a == `CDC_IDX_IRQ_FLAG) ||
                     (a == `CDC_IDX_REF_CHAN) || (a == `CDC_IDX_CMP_CTL) ||
                     (a == `CDC_IDX_IN_SEL) || (a == `CDC_IDX_LADDER) ||
                     (a == `CDC_IDX_IRQ_STAT) || (a == `CDC_IDX_IRQ_MASK) ||
                     (a == `CDC_IDX_IRQ_CLR);
        end
    endfunction

    function [4:0] db_len;
        input [1:0] sel;
        begin
            case (sel)
                2'b01:   db_len = `CDC_DB_CNT_1;
                2'b10:   db_len = `CDC_DB_CNT_2;
                2'b11:   db_len = `CDC_DB_CNT_3;
                default: db_len = 5'h00;
            endcase
        end
    endfunction

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped(idx);
    assign prdata  = prdata_r;

    // ----------------------------------------
    // compare path
    // ----------------------------------------
    wire        pd        = cmp_ctl_r[`CDC_BIT_PD];
    wire        raw_eff   = sync2_r | pd;
    wire [1:0]  dbs       = cmp_ctl_r[`CDC_DBS_HI:`CDC_DBS_LO];
    wire [1:0]  trig      = cmp_ctl_r[`CDC_TRIG_HI:`CDC_TRIG_LO];
    wire        deb_out   = (dbs == 2'b00) ? raw_eff : deb_r;
    wire        cond_nxt  = deb_out ^ cmp_ctl_r[`CDC_BIT_INV];
    reg         trig_hit;

    always @*
    begin
        case (trig)
            `CDC_TRIG_RISE: trig_hit = cond_r & ~cond_prev_r;
            `CDC_TRIG_FALL: trig_hit = ~cond_r & cond_prev_r;
            `CDC_TRIG_BOTH: trig_hit = cond_r ^ cond_prev_r;
            `CDC_TRIG_HIGH: trig_hit = cond_r;
            default:        trig_hit = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r     <= 1'b0;
            sync2_r     <= 1'b0;
            deb_r       <= 1'b1;
            deb_cnt_r   <= 5'h00;
            cond_r      <= 1'b1;
            cond_prev_r <= 1'b1;
            pin_r       <= 1'b0;
        end
        else
        begin
            sync1_r     <= comparator_raw_in;
            sync2_r     <= sync1_r;
            cond_r      <= cond_nxt;
            cond_prev_r <= cond_r;
            pin_r       <= cond_nxt;
            if (raw_eff == deb_r)
                deb_cnt_r <= 5'h00;
            else if (deb_cnt_r + 5'h01 >= db_len(dbs))
            begin
                deb_r     <= raw_eff;
                deb_cnt_r <= 5'h00;
            end
            else
                deb_cnt_r <= deb_cnt_r + 5'h01;
        end
    end

    // ----------------------------------------
    // register writes and flags
    // ----------------------------------------
    wire clr_flag = wr_en && idx == `CDC_IDX_IRQ_FLAG && !pwdata[`CDC_BIT_CMP_IRQ];
    wire clr_stat = wr_en && idx == `CDC_IDX_IRQ_CLR && pwdata[0];

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_en_r   <= `CDC_RST_IRQ_EN;
            flag_r     <= 1'b0;
            ref_chan_r <= `CDC_RST_REF_CHAN;
            cmp_ctl_r  <= `CDC_RST_CMP_CTL;
            in_sel_r   <= `CDC_RST_IN_SEL;
            ladder_r   <= `CDC_RST_LADDER;
            stat_r     <= 1'b0;
            mask_r     <= 1'b0;
        end
        else
        begin
            if (wr_en && idx == `CDC_IDX_IRQ_EN)
                irq_en_r <= pwdata[7:0] & 8'h13;
            if (wr_en && idx == `CDC_IDX_REF_CHAN)
                ref_chan_r <= pwdata[7:0] & 8'hDF;
            if (wr_en && idx == `CDC_IDX_CMP_CTL)
                cmp_ctl_r <= {pwdata[7], 1'b0, pwdata[5:0]};
            if (wr_en && idx == `CDC_IDX_IN_SEL)
                in_sel_r <= pwdata[7:0];
            if (wr_en && idx == `CDC_IDX_LADDER)
                ladder_r <= pwdata[7:0];
            if (wr_en && idx == `CDC_IDX_IRQ_MASK)
                mask_r <= pwdata[0];
            // set wins over clear
            if (trig_hit)
                flag_r <= 1'b1;
            else if (clr_flag)
                flag_r <= 1'b0;
            if (trig_hit)
                stat_r <= 1'b1;
            else if (clr_stat)
                stat_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            case (paddr[13:2])
                `CDC_IDX_IRQ_EN:   prdata_r <= {24'h000000, irq_en_r};
                `CDC_IDX_IRQ_FLAG: prdata_r <= {27'h0000000, flag_r, 4'h0};
                `CDC_IDX_REF_CHAN: prdata_r <= {24'h000000, ref_chan_r};
                `CDC_IDX_CMP_CTL:  prdata_r <= {24'h000000, cmp_ctl_r[7], raw_eff,
                                                cmp_ctl_r[5:0]};
                `CDC_IDX_IN_SEL:   prdata_r <= {24'h000000, in_sel_r};
                `CDC_IDX_LADDER:   prdata_r <= {24'h000000, ladder_r};
                `CDC_IDX_IRQ_STAT: prdata_r <= {31'h00000000, stat_r};
                `CDC_IDX_IRQ_MASK: prdata_r <= {31'h00000000, mask_r};
                default:           prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // analog controls and outputs
    // ----------------------------------------
    assign block_power_down     = pd;
    assign ladder_ref_select    = ladder_r[`CDC_BIT_LADDER_REF];
    assign bandgap_level_select = ref_chan_r[7:6];
    assign ladder_level_code    = ladder_r[6:0];
    assign neg_source_select    = in_sel_r[`CDC_BIT_NEG_SRC];
    assign neg_ext_input_select = in_sel_r[6:4];
    assign pos_ext_input_select = in_sel_r[2:0];

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_neg
            // index 2 reserved, never connected
            assign neg_pin_connect[gi] = ~in_sel_r[`CDC_BIT_NEG_SRC] && (gi != 2) &&
                                         (in_sel_r[6:4] == gi);
        end
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_pos
            assign pos_pin_connect[gi] = (in_sel_r[2:0] == gi);
        end
    endgenerate

    assign conditioned_compare_out  = cond_r;
    assign compare_pin_out          = pin_r;
    assign compare_pin_out_enable_n = ~cmp_ctl_r[`CDC_BIT_OE];
    assign compare_irq              = flag_r & irq_en_r[`CDC_BIT_CMP_IRQ];
    assign block_irq                = stat_r & mask_r;

endmodule // cdc_comparator_ctl

`default_nettype wire

// [rtl/cdc_defs.vh]
// register offsets, field positions and reset values of the comparator block
`ifndef CDC_DEFS_VH
`define CDC_DEFS_VH
// register indices (printed offsets, byte address is index times four)
`define CDC_IDX_IRQ_EN       12'h00D
`define CDC_IDX_IRQ_FLAG     12'h00E
`define CDC_IDX_REF_CHAN     12'h019
`define CDC_IDX_CMP_CTL      12'h18D
`define CDC_IDX_IN_SEL       12'h18E
`define CDC_IDX_LADDER       12'h18F
`define CDC_IDX_IRQ_STAT     12'h190
`define CDC_IDX_IRQ_MASK     12'h191
`define CDC_IDX_IRQ_CLR      12'h192
// reset values
`define CDC_RST_IRQ_EN       8'h00
`define CDC_RST_REF_CHAN     8'h1F
`define CDC_RST_CMP_CTL      8'hC0
`define CDC_RST_IN_SEL       8'hFF
`define CDC_RST_LADDER       8'h00
// field positions
`define CDC_BIT_CMP_IRQ      4
`define CDC_BIT_PD           7
`define CDC_BIT_RAW          6
`define CDC_BIT_OE           5
`define CDC_BIT_INV          4
`define CDC_TRIG_HI          3
`define CDC_TRIG_LO          2
`define CDC_DBS_HI           1
`define CDC_DBS_LO           0
`define CDC_BIT_NEG_SRC      7
`define CDC_BIT_LADDER_REF   7
// trigger modes
`define CDC_TRIG_RISE        2'b00
`define CDC_TRIG_FALL        2'b01
`define CDC_TRIG_BOTH        2'b10
`define CDC_TRIG_HIGH        2'b11
// de-bounce counts in system clock cycles
`define CDC_DB_CNT_1         5'h04
`define CDC_DB_CNT_2         5'h08
`define CDC_DB_CNT_3         5'h10
`endif
